//--- src/eag_pkg.sv
// Package for the effective address generator: modes, widths and reset values.
// Assumes the decoder and register file use these encodings.
package eag_pkg;
    localparam int EAG_AW = 20;
    localparam int EAG_BW = 16;
    localparam int EAG_KW = 4;
    localparam logic [3:0] EAG_ZK_RESET = 4'h0;
    localparam logic [15:0] EAG_IZ_RESET = 16'h0000;
    localparam logic [19:0] EAG_VECTOR_TOP = 20'h001ff;
    localparam logic [15:0] EAG_ONE = 16'h0001;
    localparam logic [15:0] EAG_TWO = 16'h0002;
    typedef enum logic [3:0] {
        EAG_ACC_OFFSET,
        EAG_LONG_ABSOLUTE,
        EAG_FULL_ABSOLUTE,
        EAG_BYTE_LITERAL,
        EAG_WORD_LITERAL,
        EAG_SHORT_INDEXED,
        EAG_WORD_INDEXED,
        EAG_FAR_INDEXED,
        EAG_IMPLIED,
        EAG_POST_UPDATE,
        EAG_SHORT_BRANCH,
        EAG_LONG_BRANCH
    } eag_mode_t;
    typedef enum logic [1:0] {
        EAG_SEL_X,
        EAG_SEL_Y,
        EAG_SEL_Z
    } eag_sel_t;
    typedef enum logic [2:0] {
        EAG_LIT_NONE,
        EAG_LIT_ADD,
        EAG_LIT_MAC,
        EAG_LIT_MASK
    } eag_lit_t;
endpackage : eag_pkg

//--- src/eag_add_if.sv
// Interface carrying one 20-bit adder request and its result.
// Assumes one combinational adder serves each instance.
`timescale 1ns/1ps
interface eag_add_if;
    logic [19:0] base;
    logic [19:0] offset;
    logic [19:0] sum;
    modport user (output base, output offset, input sum);
    modport adder (input base, input offset, output sum);
endinterface : eag_add_if

//--- src/eag_adder.sv
// Twenty-bit wrapping adder for address arithmetic.
// Assumes operands are already extended to full width.
`timescale 1ns/1ps
module eag_adder
    import eag_pkg::*;
(
    eag_add_if.adder port
);
    assign port.sum = port.base + port.offset;
endmodule : eag_adder

//--- src/eag_top.sv
// Effective address generator of the core.
// Assumes decoder and register file inputs are stable in the cycle of i_valid.
// Notes on behaviour
// - Every mode yields 16-bit byte address plus 4-bit upper part.
// - Bank crossing changes upper address bits, never stored bank fields.
// - Literal modes use the literal's own location as address.
// - Add-literal group sign-extends the byte literal to 16 bits.
// - Multiply-accumulate literal splits into two signed nibble offsets.
// - Push and pull multiple use the byte literal as register mask.
// - Long absolute: bank field above operand word.
// - Full absolute only for jump and call; 20-bit address operand.
// - Short indexed adds unsigned byte to index with its bank.
// - Word indexed adds signed word to index with its bank.
// - Far indexed adds signed 20-bit offset; jump and call only.
// - Implied mode: internal address, no operand fetch.
// - Accumulator offset sign-extends accumulator to 20 bits, adds index.
// - Taken branch adds signed offset to program bank and counter.
// - Moves use x bank and index, then add signed byte to index.
// - Low 512 bytes of bank 0 are vectors; z reset from vectors; here reset loads zk and iz with constant 0 instead.
// - Address bits 19 to 16 are bank, 15 to 0 byte address.
`timescale 1ns/1ps
module eag_top
    import eag_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire eag_mode_t i_mode,
    input wire eag_sel_t i_sel,
    input wire eag_lit_t i_lit_kind,
    input wire logic i_jump_op,
    input wire logic i_branch_taken,
    input wire logic [23:0] i_operand,
    input wire logic [15:0] i_operand_addr,
    input wire logic [15:0] i_pc,
    input wire logic [3:0] i_program_bank_field,
    input wire logic [3:0] i_extended_bank_field,
    input wire logic [15:0] i_index_reg_x,
    input wire logic [3:0] i_x_bank_field,
    input wire logic [15:0] i_index_reg_y,
    input wire logic [3:0] i_y_bank_field,
    input wire logic [15:0] i_offset_acc,
    input wire logic i_z_load,
    input wire logic [19:0] i_z_load_value,
    output logic o_ea_valid,
    output logic [19:0] o_ea,
    output logic o_fetch,
    output logic o_illegal,
    output logic o_vector_area,
    output logic [15:0] o_literal_ext,
    output logic [3:0] o_mac_x_offset,
    output logic [3:0] o_mac_y_offset,
    output logic [7:0] o_stack_mask,
    output logic o_x_update,
    output logic [15:0] o_index_reg_x_next,
    output logic [3:0] o_z_bank_field,
    output logic [15:0] o_index_reg_z
);
    typedef struct packed {
        logic ea_valid;
        logic [19:0] ea;
        logic fetch;
        logic illegal;
        logic vector_area;
        logic [15:0] literal_ext;
        logic [3:0] mac_x;
        logic [3:0] mac_y;
        logic [7:0] mask;
        logic x_update;
        logic [15:0] x_next;
        logic [3:0] zk;
        logic [15:0] iz;
    } eag_state_t;

    eag_state_t state_reg;
    eag_state_t state_next;
    logic [19:0] index_full;
    logic [19:0] pc_full;
    logic [19:0] add_offset;
    logic [19:0] add_base;
    logic [19:0] x_full;
    logic [19:0] x_step;

    eag_add_if ea_add ();
    eag_add_if mv_add ();

    eag_adder u_ea_adder (.port(ea_add));
    eag_adder u_move_adder (.port(mv_add));

    always_comb begin
        case (i_sel)
            EAG_SEL_X: index_full = {i_x_bank_field, i_index_reg_x};
            EAG_SEL_Y: index_full = {i_y_bank_field, i_index_reg_y};
            EAG_SEL_Z: index_full = {state_reg.zk, state_reg.iz};
            default: index_full = {i_x_bank_field, i_index_reg_x};
        endcase
    end

    assign pc_full = {i_program_bank_field, i_pc};
    assign x_full = {i_x_bank_field, i_index_reg_x};

    always_comb begin
        add_base = index_full;
        add_offset = '0;
        case (i_mode)
            EAG_ACC_OFFSET: add_offset = {{4{i_offset_acc[15]}}, i_offset_acc};
            EAG_SHORT_INDEXED: add_offset = {12'h000, i_operand[7:0]};
            EAG_WORD_INDEXED: add_offset = {{4{i_operand[15]}}, i_operand[15:0]};
            EAG_FAR_INDEXED: add_offset = i_operand[19:0];
            EAG_SHORT_BRANCH: begin
                add_base = pc_full;
                add_offset = {{12{i_operand[7]}}, i_operand[7:0]};
            end
            EAG_LONG_BRANCH: begin
                add_base = pc_full;
                add_offset = {{4{i_operand[15]}}, i_operand[15:0]};
            end
            default: add_offset = '0;
        endcase
    end

    assign ea_add.base = add_base;
    assign ea_add.offset = add_offset;
    assign mv_add.base = x_full;
    assign mv_add.offset = {{12{i_operand[7]}}, i_operand[7:0]};
    assign x_step = mv_add.sum;

    always_comb begin
        state_next = state_reg;
        state_next.ea_valid = 1'b0;
        state_next.x_update = 1'b0;
        if (i_z_load) begin
            state_next.zk = i_z_load_value[19:16];
            state_next.iz = i_z_load_value[15:0];
        end
        if (i_valid) begin
            state_next.ea_valid = 1'b1;
            state_next.fetch = 1'b1;
            state_next.illegal = 1'b0;
            state_next.ea = ea_add.sum;
            case (i_mode)
                EAG_ACC_OFFSET, EAG_SHORT_INDEXED, EAG_WORD_INDEXED: begin
                    state_next.ea = ea_add.sum;
                end
                EAG_FAR_INDEXED: begin
                    state_next.illegal = ~i_jump_op;
                end
                EAG_LONG_ABSOLUTE: begin
                    state_next.ea = {i_extended_bank_field, i_operand[15:0]};
                end
                EAG_FULL_ABSOLUTE: begin
                    state_next.ea = i_operand[19:0];
                    state_next.illegal = ~i_jump_op;
                end
                EAG_BYTE_LITERAL, EAG_WORD_LITERAL: begin
                    state_next.ea = {i_program_bank_field, i_operand_addr};
                    state_next.literal_ext = {{8{i_operand[7]}}, i_operand[7:0]};
                    state_next.mac_x = i_operand[7:4];
                    state_next.mac_y = i_operand[3:0];
                    state_next.mask = i_operand[7:0];
                    if (i_mode == EAG_WORD_LITERAL) begin
                        state_next.literal_ext = i_operand[15:0];
                    end
                end
                EAG_IMPLIED: begin
                    state_next.ea = pc_full;
                    state_next.fetch = 1'b0;
                end
                EAG_POST_UPDATE: begin
                    state_next.ea = x_full;
                    state_next.x_update = 1'b1;
                    state_next.x_next = x_step[15:0];
                end
                EAG_SHORT_BRANCH, EAG_LONG_BRANCH: begin
                    state_next.ea = i_branch_taken ? ea_add.sum : pc_full;
                    state_next.fetch = 1'b0;
                end
                default: state_next.illegal = 1'b1;
            endcase
            state_next.vector_area = (state_next.ea <= EAG_VECTOR_TOP);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg <= '0;
            state_reg.zk <= EAG_ZK_RESET;
            state_reg.iz <= EAG_IZ_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_ea_valid = state_reg.ea_valid;
    assign o_ea = state_reg.ea;
    assign o_fetch = state_reg.fetch;
    assign o_illegal = state_reg.illegal;
    assign o_vector_area = state_reg.vector_area;
    assign o_literal_ext = state_reg.literal_ext;
    assign o_mac_x_offset = state_reg.mac_x;
    assign o_mac_y_offset = state_reg.mac_y;
    assign o_stack_mask = state_reg.mask;
    assign o_x_update = state_reg.x_update;
    assign o_index_reg_x_next = state_reg.x_next;
    assign o_z_bank_field = state_reg.zk;
    assign o_index_reg_z = state_reg.iz;

    property p_long_abs;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_LONG_ABSOLUTE
        |=> o_ea == {$past(i_extended_bank_field), $past(i_operand[15:0])};
    endproperty
    a_long_abs: assert property (p_long_abs) else $error("Long absolute address wrong.");

    property p_short_idx;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_SHORT_INDEXED && i_sel == EAG_SEL_X
        |=> o_ea == 20'({$past(i_x_bank_field), $past(i_index_reg_x)}
            + {12'h000, $past(i_operand[7:0])});
    endproperty
    a_short_idx: assert property (p_short_idx) else $error("Short indexed sum wrong.");

    property p_word_idx;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_WORD_INDEXED && i_sel == EAG_SEL_Y
        |=> o_ea == 20'({$past(i_y_bank_field), $past(i_index_reg_y)}
            + {{4{$past(i_operand[15])}}, $past(i_operand[15:0])});
    endproperty
    a_word_idx: assert property (p_word_idx) else $error("Word indexed sum wrong.");

    property p_full_abs_jump;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && (i_mode == EAG_FULL_ABSOLUTE || i_mode == EAG_FAR_INDEXED)
        |=> o_illegal == !$past(i_jump_op);
    endproperty
    a_full_abs_jump: assert property (p_full_abs_jump) else $error("Jump-only check wrong.");

    property p_implied;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_IMPLIED |=> o_ea_valid && !o_fetch;
    endproperty
    a_implied: assert property (p_implied) else $error("Implied mode fetched.");

    property p_branch;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_SHORT_BRANCH && i_branch_taken
        |=> o_ea == 20'({$past(i_program_bank_field), $past(i_pc)}
            + {{12{$past(i_operand[7])}}, $past(i_operand[7:0])});
    endproperty
    a_branch: assert property (p_branch) else $error("Branch target wrong.");

    property p_move;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_POST_UPDATE
        |=> o_x_update && o_ea == {$past(i_x_bank_field), $past(i_index_reg_x)}
        ##1 o_x_update == ($past(i_valid) && $past(i_mode) == EAG_POST_UPDATE);
    endproperty
    a_move: assert property (p_move) else $error("Move address wrong.");

    property p_literal;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_BYTE_LITERAL
        |=> o_literal_ext == {{8{$past(i_operand[7])}}, $past(i_operand[7:0])}
            && o_stack_mask == $past(i_operand[7:0]);
    endproperty
    a_literal: assert property (p_literal) else $error("Literal split wrong.");

    property p_acc;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_ACC_OFFSET && i_sel == EAG_SEL_Z
        |=> o_ea == 20'({$past(o_z_bank_field), $past(o_index_reg_z)}
            + {{4{$past(i_offset_acc[15])}}, $past(i_offset_acc)});
    endproperty
    a_acc: assert property (p_acc) else $error("Accumulator offset wrong.");

    property p_reset_z;
        @(posedge i_clk) !i_resetn |=> o_z_bank_field == EAG_ZK_RESET && !o_ea_valid;
    endproperty
    a_reset_z: assert property (p_reset_z) else $error("Z reset value wrong.");

    property p_far_idx;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_FAR_INDEXED && i_sel == EAG_SEL_X
        |=> o_ea == 20'({$past(i_x_bank_field), $past(i_index_reg_x)}
            + $past(i_operand[19:0]));
    endproperty
    a_far_idx: assert property (p_far_idx) else $error("Far indexed sum wrong.");

    property p_full_abs;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_FULL_ABSOLUTE |=> o_ea == $past(i_operand[19:0]);
    endproperty
    a_full_abs: assert property (p_full_abs) else $error("Full absolute address wrong.");

    property p_lit_addr;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && (i_mode == EAG_BYTE_LITERAL || i_mode == EAG_WORD_LITERAL)
        |=> o_fetch && o_ea == {$past(i_program_bank_field), $past(i_operand_addr)};
    endproperty
    a_lit_addr: assert property (p_lit_addr) else $error("Literal address wrong.");

    property p_mac_split;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_BYTE_LITERAL
        |=> o_mac_x_offset == $past(i_operand[7:4])
            && o_mac_y_offset == $past(i_operand[3:0]);
    endproperty
    a_mac_split: assert property (p_mac_split) else $error("Offset split wrong.");

    property p_long_branch;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_LONG_BRANCH && i_branch_taken
        |=> o_ea == 20'({$past(i_program_bank_field), $past(i_pc)}
            + {{4{$past(i_operand[15])}}, $past(i_operand[15:0])});
    endproperty
    a_long_branch: assert property (p_long_branch) else $error("Long branch wrong.");

    property p_not_taken;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && (i_mode == EAG_SHORT_BRANCH || i_mode == EAG_LONG_BRANCH) && !i_branch_taken
        |=> !o_fetch && o_ea == {$past(i_program_bank_field), $past(i_pc)};
    endproperty
    a_not_taken: assert property (p_not_taken) else $error("Untaken branch wrong.");

    property p_move_next;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_mode == EAG_POST_UPDATE
        |=> o_index_reg_x_next == 16'($past(i_index_reg_x)
            + {{8{$past(i_operand[7])}}, $past(i_operand[7:0])});
    endproperty
    a_move_next: assert property (p_move_next) else $error("Move index update wrong.");

    property p_vector;
        @(posedge i_clk) disable iff (!i_resetn)
        o_ea_valid |-> o_vector_area == (o_ea <= EAG_VECTOR_TOP);
    endproperty
    a_vector: assert property (p_vector) else $error("Vector area flag wrong.");

    property p_z_load;
        @(posedge i_clk) disable iff (!i_resetn)
        i_z_load |=> o_z_bank_field == $past(i_z_load_value[19:16])
            && o_index_reg_z == $past(i_z_load_value[15:0]);
    endproperty
    a_z_load: assert property (p_z_load) else $error("Z load wrong.");

    property p_z_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !i_z_load |=> $stable(o_z_bank_field) && $stable(o_index_reg_z);
    endproperty
    a_z_hold: assert property (p_z_hold) else $error("Bank field changed by address.");

    property p_answer;
        @(posedge i_clk) disable iff (!i_resetn)
        1'b1 |=> o_ea_valid == $past(i_valid);
    endproperty
    a_answer: assert property (p_answer) else $error("Answer pulse wrong.");

    c_illegal: cover property (@(posedge i_clk) o_ea_valid && o_illegal);
    c_branch: cover property (@(posedge i_clk) i_valid && i_mode == EAG_LONG_BRANCH);
    c_move: cover property (@(posedge i_clk) i_valid && i_mode == EAG_POST_UPDATE);
    c_cross: cover property (@(posedge i_clk) o_ea_valid && o_ea[19:16] != $past(i_x_bank_field));
endmodule : eag_top

//--- sim/eag_regfile_model.sv
// Register file model that feeds index, bank, program and accumulator values.
// Assumes moves are reported by a one-cycle update pulse from the generator.
`timescale 1ns/1ps
module eag_regfile_model
    import eag_pkg::*;
#(
    parameter logic [15:0] X_RESET = 16'hfff0
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_x_update,
    input wire logic [15:0] i_index_reg_x_next,
    output logic [15:0] o_index_reg_x,
    output logic [3:0] o_x_bank_field,
    output logic [15:0] o_index_reg_y,
    output logic [3:0] o_y_bank_field,
    output logic [15:0] o_offset_acc,
    output logic [15:0] o_pc,
    output logic [3:0] o_program_bank_field,
    output logic [3:0] o_extended_bank_field
);
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_index_reg_x <= X_RESET;
        end else if (i_x_update) begin
            o_index_reg_x <= i_index_reg_x_next;
        end
    end
    // Bank fields stay put whatever the generator computes.
    assign o_x_bank_field = 4'h2;
    assign o_index_reg_y = 16'h1000;
    assign o_y_bank_field = 4'hf;
    assign o_offset_acc = 16'hff80;
    assign o_pc = 16'hfffe;
    assign o_program_bank_field = 4'h3;
    assign o_extended_bank_field = 4'h5;
endmodule : eag_regfile_model

//--- sim/tb_top.sv
// Self-checking testbench for the effective address generator.
// Assumes the register file model values for index, bank and program fields.
`timescale 1ns/1ps
module tb_top
    import eag_pkg::*;
;
    logic clk = 0, rstn = 0, vld = 0, jump_op = 0, tkn = 0, zld = 0;
    eag_mode_t mode = EAG_IMPLIED;
    eag_sel_t sel = EAG_SEL_X;
    logic [23:0] opnd = 24'h0;
    logic [15:0] oaddr = 16'h2000;
    logic [19:0] zval = 20'h0;
    logic ea_v, fetch, ill, vec, xu;
    logic [19:0] ea;
    logic [15:0] lext, xn, iz, x, y, e, pc;
    logic [3:0] mx, my, zk, xk, yk, pk, ek;
    logic [7:0] mask;
    int n_mismatch = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    eag_regfile_model rf (.i_clk(clk), .i_resetn(rstn), .i_x_update(xu),
        .i_index_reg_x_next(xn), .o_index_reg_x(x), .o_x_bank_field(xk),
        .o_index_reg_y(y), .o_y_bank_field(yk), .o_offset_acc(e), .o_pc(pc),
        .o_program_bank_field(pk), .o_extended_bank_field(ek));
    eag_top dut (.i_clk(clk), .i_resetn(rstn), .i_valid(vld), .i_mode(mode), .i_sel(sel),
        .i_lit_kind(EAG_LIT_NONE), .i_jump_op(jump_op), .i_branch_taken(tkn), .i_operand(opnd),
        .i_operand_addr(oaddr), .i_pc(pc), .i_program_bank_field(pk),
        .i_extended_bank_field(ek), .i_index_reg_x(x), .i_x_bank_field(xk),
        .i_index_reg_y(y), .i_y_bank_field(yk), .i_offset_acc(e), .i_z_load(zld),
        .i_z_load_value(zval), .o_ea_valid(ea_v), .o_ea(ea), .o_fetch(fetch),
        .o_illegal(ill), .o_vector_area(vec), .o_literal_ext(lext), .o_mac_x_offset(mx),
        .o_mac_y_offset(my), .o_stack_mask(mask), .o_x_update(xu),
        .o_index_reg_x_next(xn), .o_z_bank_field(zk), .o_index_reg_z(iz));
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk_ea(input logic [19:0] g, input logic [19:0] w);
        n_checks++;
        if (g !== w) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, w);
        end
    endtask : chk_ea
    task automatic chk_w(input logic [15:0] g, input logic [15:0] w);
        chk_ea({4'h0, g}, {4'h0, w});
    endtask : chk_w
    task automatic chk_b(input logic g, input logic w);
        chk_ea({19'h0, g}, {19'h0, w});
    endtask : chk_b
    task automatic req(input eag_mode_t m, input eag_sel_t s, input logic [23:0] op,
                       input logic j, input logic t);
        int k;
        @(posedge clk);
        mode <= m;
        sel <= s;
        opnd <= op;
        jump_op <= j;
        tkn <= t;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        k = 0;
        while (ea_v !== 1'b1 && k < 4) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_w(16'(k), 16'h0000);
        if (k == 4) begin
            test_done();
        end
    endtask : req
    task automatic zload(input logic [19:0] v);
        @(posedge clk);
        zld <= 1'b1;
        zval <= v;
        @(posedge clk);
        zld <= 1'b0;
        #1;
        chk_ea({zk, iz}, v);
    endtask : zload
    task automatic t_abs;
        req(EAG_LONG_ABSOLUTE, EAG_SEL_X, 24'h001234, 1'b0, 1'b0);
        chk_ea(ea, 20'h51234);
        chk_b(fetch, 1'b1);
        req(EAG_FULL_ABSOLUTE, EAG_SEL_X, 24'h0abcde, 1'b1, 1'b0);
        chk_ea(ea, 20'habcde);
        chk_b(ill, 1'b0);
        req(EAG_FULL_ABSOLUTE, EAG_SEL_X, 24'h0abcde, 1'b0, 1'b0);
        chk_b(ill, 1'b1);
        $display("done absolute");
    endtask : t_abs
    task automatic t_lit;
        req(EAG_BYTE_LITERAL, EAG_SEL_X, 24'h00008a, 1'b0, 1'b0);
        chk_ea(ea, 20'h32000);
        chk_w(lext, 16'hff8a);
        chk_w({8'h00, mx, my}, 16'h008a);
        chk_w({8'h00, mask}, 16'h008a);
        req(EAG_WORD_LITERAL, EAG_SEL_X, 24'h001234, 1'b0, 1'b0);
        chk_ea(ea, 20'h32000);
        chk_w(lext, 16'h1234);
        $display("done literal");
    endtask : t_lit
    task automatic t_idx;
        req(EAG_SHORT_INDEXED, EAG_SEL_X, 24'h0000ff, 1'b0, 1'b0);
        chk_ea(ea, 20'h300ef);
        req(EAG_WORD_INDEXED, EAG_SEL_Y, 24'h008000, 1'b0, 1'b0);
        chk_ea(ea, 20'he9000);
        req(EAG_FAR_INDEXED, EAG_SEL_X, 24'h0fffff, 1'b1, 1'b0);
        chk_ea(ea, 20'h2ffef);
        req(EAG_FAR_INDEXED, EAG_SEL_X, 24'h0fffff, 1'b0, 1'b0);
        chk_b(ill, 1'b1);
        zload(20'h00100);
        req(EAG_SHORT_INDEXED, EAG_SEL_Z, 24'h0000ff, 1'b0, 1'b0);
        chk_ea(ea, 20'h001ff);
        chk_b(vec, 1'b1);
        zload(20'h4ff80);
        req(EAG_WORD_INDEXED, EAG_SEL_Z, 24'h000100, 1'b0, 1'b0);
        chk_ea(ea, 20'h50080);
        chk_b(vec, 1'b0);
        chk_ea({zk, iz}, 20'h4ff80);
        req(EAG_ACC_OFFSET, EAG_SEL_Z, 24'h000000, 1'b0, 1'b0);
        chk_ea(ea, 20'h4ff00);
        req(EAG_ACC_OFFSET, EAG_SEL_X, 24'h000000, 1'b0, 1'b0);
        chk_ea(ea, 20'h2ff70);
        $display("done indexed");
    endtask : t_idx
    task automatic t_rel;
        req(EAG_IMPLIED, EAG_SEL_X, 24'h000000, 1'b0, 1'b0);
        chk_ea(ea, 20'h3fffe);
        chk_b(fetch, 1'b0);
        req(EAG_SHORT_BRANCH, EAG_SEL_X, 24'h000004, 1'b0, 1'b1);
        chk_ea(ea, 20'h40002);
        req(EAG_LONG_BRANCH, EAG_SEL_X, 24'h00fffc, 1'b0, 1'b1);
        chk_ea(ea, 20'h3fffa);
        req(EAG_SHORT_BRANCH, EAG_SEL_X, 24'h000004, 1'b0, 1'b0);
        chk_ea(ea, 20'h3fffe);
        $display("done relative");
    endtask : t_rel
    task automatic t_move;
        req(EAG_POST_UPDATE, EAG_SEL_X, 24'h000020, 1'b0, 1'b0);
        chk_ea(ea, 20'h2fff0);
        chk_b(xu, 1'b1);
        chk_w(xn, 16'h0010);
        req(EAG_POST_UPDATE, EAG_SEL_X, 24'h0000f0, 1'b0, 1'b0);
        chk_ea(ea, 20'h20010);
        chk_w(xn, 16'h0000);
        @(posedge clk);
        #1;
        chk_b(xu, 1'b0);
        $display("done move");
    endtask : t_move
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk_ea({zk, iz}, 20'h00000);
        $display("done reset");
        @(posedge clk);
        rstn <= 1'b1;
        t_abs();
        t_lit();
        t_idx();
        t_rel();
        t_move();
        test_done();
    end
endmodule : tb_top
